// ---- src/swc_cfg.svh ----
// constants for the sleep and wake controller
`ifndef SWC_CFG_SVH
`define SWC_CFG_SVH
// register byte addresses on the apb bus
`define SWC_ADDR_FLAGS1   8'h00
`define SWC_ADDR_FLAGS2   8'h04
`define SWC_ADDR_CTRL     8'h08
`define SWC_ADDR_STATUS   8'h0C
// flag positions in the request flag registers
`define SWC_BIT_CONV      6
`define SWC_BIT_SSP       3
`define SWC_BIT_BCL       3
// control register fields
`define SWC_CTL_GIE       0
`define SWC_CTL_PERIPHERAL_IRQ_ENABLE      1
`define SWC_CTL_CONV_EN   2
`define SWC_CTL_SSP_EN    3
`define SWC_CTL_BCL_EN    4
`define SWC_CTL_EXT_EN    5
`define SWC_CTL_WDT_SLP   6
`define SWC_CTL_EXTERNAL_RESET_PIN_EN   7
`define SWC_CTL_BOR_EN    8
`define SWC_CTL_OSC_HI    10
`define SWC_CTL_OSC_LO    9
`define SWC_CTL_CONV_DED  11
`define SWC_CTL_W         12
`define SWC_CTL_RST       12'h000
// status register fields
`define SWC_ST_PD_N       0
`define SWC_ST_TO_N       1
`define SWC_ST_SLEEP      2
// reset values
`define SWC_FLAGS_RST     8'h00
`define SWC_OSC_INTERNAL  2'h0
// oscillator start-up delay, in oscillator periods
`define SWC_OST_PERIODS   1024
`define SWC_CLK_PER_OSC   1
`define SWC_OST_CYCLES    (`SWC_OST_PERIODS * `SWC_CLK_PER_OSC)
`define SWC_OST_W         11
// fixed interrupt vector address
`define SWC_IRQ_VECTOR    16'h0004
`endif

// ---- src/swc_pkg.sv ----
// types for the sleep and wake controller
package swc_pkg;
  // power state of the controller
  typedef enum logic [1:0] {
    SWC_AWAKE  = 2'b00,
    SWC_SLEEP  = 2'b01,
    SWC_OST    = 2'b10,
    SWC_RESUME = 2'b11
  } swc_state_type;
endpackage : swc_pkg

// ---- src/swc_sleep_wake.sv ----
// sleep entry, wake-up and peripheral request flags behind an apb slave
//
// What this block does
// - power-down only by sleep instruction
// - entry clears watchdog, may keep it counting
// - entry clears power-down bit, sets time-out bit
// - processor clock gated off while asleep
// - low-frequency oscillator keeps running asleep
// - converter runs asleep on dedicated clock
// - i/o ports hold their drive state
// - non-watchdog resets act same asleep
// - five wake events leave power-down
// - pin, brown-out, power-on wakes reset device
// - next instruction prefetched during sleep
// - enabled source wakes, global enable ignored
// - resume in line, then call service routine
// - service call goes to fixed vector
// - crystal modes wait 1024 oscillator periods
// - watchdog cleared on every wake
// - pending enabled flag, global enable off, makes sleep a no-op
// - late flag completes sleep, wakes at once
// - flags set regardless of enable bits
// - first flag register layout, reset zero
// - second flag register layout, reset zero
// - peripheral sources need peripheral enable
`timescale 1ns/1ps
`include "swc_cfg.svh"

module swc_sleep_wake (
  input  wire logic                  clk,              // system clock
  input  wire logic                  reset_n,          // async reset
  input  wire logic                  psel,             // apb select
  input  wire logic                  penable,          // apb enable
  input  wire logic                  pwrite,           // apb direction
  input  wire logic [7:0]            paddr,            // apb address
  input  wire logic [31:0]           pwdata,           // apb write data
  output logic      [31:0]           prdata,           // apb read data
  output logic                       pready,           // apb ready
  output logic                       pslverr,          // apb error
  input  wire logic                  sleep_instr,      // core runs sleep
  input  wire logic                  converter_done,   // converter event
  input  wire logic                  serial_port_evt,  // serial event
  input  wire logic                  bus_collision_evt,// collision event
  input  wire logic                  ext_irq_pin,      // external irq pin
  input  wire logic                  external_reset_pin, // reset pin
  input  wire logic                  brown_out_reset,  // brown-out detect
  input  wire logic                  power_on_reset,   // power-on detect
  input  wire logic                  wdt_timeout,      // watchdog expiry
  output logic                       core_clk_en,      // core clock gate
  output logic                       prefetch_next,    // fetch pc plus one
  output logic                       sleep_nop,        // sleep was a no-op
  output logic                       resume,           // core resumes
  output logic                       isr_call,         // call after next
  output logic      [15:0]           irq_vector,       // service address
  output logic                       irq_pending,      // enabled irq seen
  output logic                       wdt_clear,        // watchdog clear
  output logic                       wdt_sleep_run,    // wdt counts asleep
  output logic                       lf_osc_run,       // low-freq osc on
  output logic                       conv_clk_run,     // converter clocked
  output logic                       io_hold,          // freeze port drive
  output logic                       device_reset_req, // device reset
  output swc_pkg::swc_state_type     power_state       // controller state
);
  import swc_pkg::*;

  // write merge where a hardware set beats a software clear
  function automatic logic set_wins(
    input logic old_v,
    input logic wen,
    input logic wbit,
    input logic evt
  );
    set_wins = (wen ? wbit : old_v) | evt;
  endfunction : set_wins

  // pin inputs: ext irq, reset pin, brown-out, power-on, watchdog
  logic [4:0]              sync1_ff;       // first stage, read by sync2
  logic [4:0]              sync2_ff;       // stable copies
  logic                    ext_s;          // synced external irq
  logic                    external_reset_pin_s;         // synced reset pin
  logic                    bor_s;          // synced brown-out
  logic                    por_s;          // synced power-on
  logic                    wdt_s;          // synced watchdog expiry

  // register state
  logic                    conv_flag_ff;   // converter_irq_flag
  logic                    ssp_flag_ff;    // serial_port_irq_flag
  logic                    bcl_flag_ff;    // bus_collision_irq_flag
  logic [`SWC_CTL_W-1:0]   ctrl_ff;        // enables and modes
  logic                    pd_n_ff;        // power_down_status_n
  logic                    to_n_ff;        // time_out_status_n
  swc_state_type           state_ff;       // power state
  swc_state_type           nxt_state;      // next power state
  logic [`SWC_OST_W-1:0]   ost_cnt_ff;     // start-up countdown

  // bus decode
  logic                    access;         // access phase, not answered
  logic                    hit_f1;         // first flag register
  logic                    hit_f2;         // second flag register
  logic                    hit_ctl;        // control register
  logic                    hit_st;         // status register
  logic                    hit_any;        // mapped address
  logic                    wr_f1;          // write strobe flags 1
  logic                    wr_f2;          // write strobe flags 2
  logic                    wr_ctl;         // write strobe control
  logic [7:0]              flags1_rd;      // flags 1 read view
  logic [7:0]              flags2_rd;      // flags 2 read view
  logic [7:0]              status_rd;      // status read view
  logic [31:0]             rd_word;        // selected read word

  // sleep decisions
  logic                    global_irq_enable;            // global_irq_enable
  logic                    peripheral_irq_enable;           // peripheral_irq_enable
  logic                    periph_pend;    // enabled peripheral flag
  logic                    pend;           // any enabled request
  logic                    sleep_take;     // sleep seen while awake
  logic                    nop_take;       // sleep becomes a no-op
  logic                    sleep_go;       // sleep really entered
  logic                    wdt_wake;       // watchdog expiry asleep
  logic                    wake;           // leave power-down
  logic                    xtal_mode;      // crystal-type oscillator
  logic                    ost_done;       // start-up delay elapsed
  logic                    asleep;         // clock gated states

  // split synchronised pins
  assign ext_s  = sync2_ff[0];
  assign external_reset_pin_s = sync2_ff[1];
  assign bor_s  = sync2_ff[2];
  assign por_s  = sync2_ff[3];
  assign wdt_s  = sync2_ff[4];

  // address decode; answer comes one cycle into the access phase and
  // writes land only at the edge where ready is seen high
  assign access  = psel & penable & ~pready;
  assign hit_f1  = (paddr == `SWC_ADDR_FLAGS1);
  assign hit_f2  = (paddr == `SWC_ADDR_FLAGS2);
  assign hit_ctl = (paddr == `SWC_ADDR_CTRL);
  assign hit_st  = (paddr == `SWC_ADDR_STATUS);
  assign hit_any = hit_f1 | hit_f2 | hit_ctl | hit_st;
  assign wr_f1   = psel & penable & pready & pwrite & hit_f1;
  assign wr_f2   = psel & penable & pready & pwrite & hit_f2;
  assign wr_ctl  = psel & penable & pready & pwrite & hit_ctl;

  // first flag register, unused bits zero
  assign flags1_rd = {1'b0, conv_flag_ff, 2'b00, ssp_flag_ff, 3'b000};
  // second flag register, unused bits zero
  assign flags2_rd = {4'h0, bcl_flag_ff, 3'b000};
  assign status_rd = {5'h00, asleep, to_n_ff, pd_n_ff};

  // read mux; unmapped reads return zero with an error
  assign rd_word = hit_f1  ? {24'h000000, flags1_rd} :
                   hit_f2  ? {24'h000000, flags2_rd} :
                   hit_ctl ? {20'h00000, ctrl_ff} :
                   hit_st  ? {24'h000000, status_rd} : 32'h00000000;

  // enables
  assign global_irq_enable  = ctrl_ff[`SWC_CTL_GIE];
  assign peripheral_irq_enable = ctrl_ff[`SWC_CTL_PERIPHERAL_IRQ_ENABLE];
  // peripheral enable gates all peripheral sources
  assign periph_pend = peripheral_irq_enable &
    ((conv_flag_ff & ctrl_ff[`SWC_CTL_CONV_EN]) |
     (ssp_flag_ff  & ctrl_ff[`SWC_CTL_SSP_EN]) |
     (bcl_flag_ff  & ctrl_ff[`SWC_CTL_BCL_EN]));
  // individual enable needed, global enable not
  assign pend = periph_pend | (ext_s & ctrl_ff[`SWC_CTL_EXT_EN]);

  // only the sleep instruction starts power-down
  assign sleep_take = sleep_instr & (state_ff == SWC_AWAKE);
  // request already pending with global enable off
  assign nop_take   = sleep_take & pend & ~global_irq_enable;
  assign sleep_go   = sleep_take & ~nop_take;
  // watchdog wakes only when it runs in sleep
  assign wdt_wake   = wdt_s & ctrl_ff[`SWC_CTL_WDT_SLP];
  // a request that arrives late wakes at once
  assign wake       = (state_ff == SWC_SLEEP) & (pend | wdt_wake);
  assign xtal_mode  = ctrl_ff[`SWC_CTL_OSC_HI:`SWC_CTL_OSC_LO] !=
                      `SWC_OSC_INTERNAL;
  assign ost_done   = (state_ff == SWC_OST) &&
                      (ost_cnt_ff == `SWC_OST_W'(0));
  assign asleep     = (state_ff == SWC_SLEEP) | (state_ff == SWC_OST);

  // next power state
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      SWC_AWAKE: begin
        if (sleep_go) begin
          nxt_state = SWC_SLEEP;
        end
      end
      SWC_SLEEP: begin
        // crystal-type modes wait for the oscillator
        if (wake) begin
          nxt_state = xtal_mode ? SWC_OST : SWC_RESUME;
        end
      end
      SWC_OST: begin
        if (ost_done) begin
          nxt_state = SWC_RESUME;
        end
      end
      SWC_RESUME: begin
        nxt_state = SWC_AWAKE;
      end
    endcase
  end

  // two-flop synchronisers for pin inputs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_ff <= 5'h00;
      sync2_ff <= 5'h00;
    end else begin
      sync1_ff <= {wdt_timeout, power_on_reset, brown_out_reset,
                   external_reset_pin, ext_irq_pin};
      sync2_ff <= sync1_ff;
    end
  end

  // apb answer, registered so the outputs come from flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= access;
      pslverr <= access & ~hit_any;
      prdata  <= access ? rd_word : 32'h00000000;
    end
  end

  // request flags; an event in the clearing cycle still sets the flag
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      conv_flag_ff <= 1'(`SWC_FLAGS_RST >> `SWC_BIT_CONV);
      ssp_flag_ff  <= 1'(`SWC_FLAGS_RST >> `SWC_BIT_SSP);
      bcl_flag_ff  <= 1'(`SWC_FLAGS_RST >> `SWC_BIT_BCL);
    end else begin
      // events set flags whatever the enables
      conv_flag_ff <= set_wins(conv_flag_ff, wr_f1,
                               pwdata[`SWC_BIT_CONV], converter_done);
      ssp_flag_ff  <= set_wins(ssp_flag_ff, wr_f1,
                               pwdata[`SWC_BIT_SSP], serial_port_evt);
      bcl_flag_ff  <= set_wins(bcl_flag_ff, wr_f2,
                               pwdata[`SWC_BIT_BCL], bus_collision_evt);
    end
  end

  // control register, fully software owned
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_ff <= `SWC_CTL_RST;
    end else if (wr_ctl) begin
      ctrl_ff <= pwdata[`SWC_CTL_W-1:0];
    end
  end

  // status bits; a no-op sleep leaves both untouched
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pd_n_ff <= 1'b1;
      to_n_ff <= 1'b1;
    end else if (sleep_go) begin
      // power-down bit low, time-out bit high
      pd_n_ff <= 1'b0;
      to_n_ff <= 1'b1;
    end else if (wake && !pend) begin
      // watchdog-only wake marks the time-out
      to_n_ff <= 1'b0;
    end
  end

  // state register and start-up countdown
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff   <= SWC_AWAKE;
      ost_cnt_ff <= `SWC_OST_W'(0);
    end else begin
      state_ff <= nxt_state;
      // count 1024 periods, reaching zero on the last
      if (wake) begin
        ost_cnt_ff <= `SWC_OST_W'(`SWC_OST_CYCLES - 1);
      end else if (state_ff == SWC_OST) begin
        ost_cnt_ff <= ost_cnt_ff - `SWC_OST_W'(1);
      end
    end
  end

  // core facing pulses and levels
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      core_clk_en   <= 1'b1;
      prefetch_next <= 1'b0;
      sleep_nop     <= 1'b0;
      resume        <= 1'b0;
      isr_call      <= 1'b0;
      irq_vector    <= `SWC_IRQ_VECTOR;
      irq_pending   <= 1'b0;
      power_state   <= SWC_AWAKE;
    end else begin
      // no core clock through sleep and start-up
      core_clk_en   <= (nxt_state == SWC_AWAKE) |
                       (nxt_state == SWC_RESUME);
      prefetch_next <= sleep_take;
      sleep_nop     <= nop_take;
      resume        <= (state_ff == SWC_RESUME);
      // call after the next instruction if enabled
      isr_call      <= (state_ff == SWC_RESUME) & global_irq_enable;
      // service routine sits at the fixed vector
      irq_vector    <= `SWC_IRQ_VECTOR;
      irq_pending   <= global_irq_enable & pend & ~asleep;
      power_state   <= nxt_state;
    end
  end

  // watchdog, clock tree, ports and reset requests
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wdt_clear        <= 1'b0;
      wdt_sleep_run    <= 1'b0;
      lf_osc_run       <= 1'b1;
      conv_clk_run     <= 1'b1;
      io_hold          <= 1'b0;
      device_reset_req <= 1'b0;
    end else begin
      // clear on entry; clear on every wake
      wdt_clear     <= sleep_go | wake;
      // keeps counting only if enabled for sleep
      wdt_sleep_run <= (nxt_state == SWC_SLEEP) &
                       ctrl_ff[`SWC_CTL_WDT_SLP];
      lf_osc_run    <= 1'b1;
      // converter clock survives on its own source
      conv_clk_run  <= ~((nxt_state == SWC_SLEEP) |
                         (nxt_state == SWC_OST)) |
                       ctrl_ff[`SWC_CTL_CONV_DED];
      // port drive frozen while the core is stopped
      io_hold       <= (nxt_state == SWC_SLEEP) |
                       (nxt_state == SWC_OST);
      // reset sources pass in any state
      device_reset_req <= (external_reset_pin_s & ctrl_ff[`SWC_CTL_EXTERNAL_RESET_PIN_EN]) |
                          (bor_s & ctrl_ff[`SWC_CTL_BOR_EN]) | por_s;
    end
  end

endmodule : swc_sleep_wake

// ---- tb/swc_sleep_wake_props.sv ----
// port checker for the sleep and wake controller
`timescale 1ns/1ps
`include "swc_cfg.svh"
module swc_sleep_wake_props (
  input wire logic                   clk,              // system clock
  input wire logic                   reset_n,          // async reset
  input wire logic                   psel,             // apb select
  input wire logic                   penable,          // apb enable
  input wire logic                   pready,           // apb ready
  input wire logic                   sleep_instr,      // core runs sleep
  input wire logic                   core_clk_en,      // core clock gate
  input wire logic                   prefetch_next,    // prefetch pulse
  input wire logic                   sleep_nop,        // no-op sleep
  input wire logic                   resume,           // core resumes
  input wire logic                   isr_call,         // service call
  input wire logic [15:0]            irq_vector,       // service address
  input wire logic                   wdt_clear,        // watchdog clear
  input wire logic                   lf_osc_run,       // slow osc on
  input wire logic                   io_hold,          // port freeze
  input wire logic                   power_on_reset,   // power-on detect
  input wire logic                   device_reset_req, // device reset
  input wire swc_pkg::swc_state_type power_state       // controller state
);
  import swc_pkg::*;
  logic [11:0] ost_ff;  // cycles spent in start-up wait
  logic [11:0] nxt_ost; // wide enough to show an overrun
  assign nxt_ost = (power_state == SWC_OST) ? ost_ff + 12'h001 : 12'h000;
  // count start-up cycles, cleared in any other state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) ost_ff <= 12'h000;
    else ost_ff <= nxt_ost;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sleep_cause_a: assert property ($rose(io_hold) |-> $past(sleep_instr))
    else $error("sleep entered without instruction");
  entry_clear_a: assert property ($rose(io_hold) |-> wdt_clear)
    else $error("watchdog not cleared on entry");
  clk_gate_a: assert property (io_hold |-> !core_clk_en)
    else $error("core clock runs while asleep");
  port_hold_a: assert property (power_state inside {SWC_SLEEP, SWC_OST}
    |-> io_hold) else $error("ports not held asleep");
  osc_run_a: assert property (lf_osc_run)
    else $error("slow oscillator stopped");
  prefetch_next_a: assert property (sleep_instr && power_state == SWC_AWAKE
    |=> prefetch_next) else $error("no prefetch after sleep");
  nop_quiet_a: assert property (sleep_nop |-> core_clk_en && !wdt_clear
    && !io_hold) else $error("no-op sleep had side effects");
  isr_vector_a: assert property (isr_call |-> resume
    && irq_vector == `SWC_IRQ_VECTOR) else $error("bad service call");
  ost_wait_a: assert property (power_state == SWC_RESUME
    && $past(power_state) == SWC_OST |-> ost_ff == 12'h400)
    else $error("start-up wait length wrong");
  wake_clear_a: assert property ($past(power_state) == SWC_SLEEP
    && power_state != SWC_SLEEP |-> wdt_clear)
    else $error("watchdog not cleared on wake");
  reset_req_a: assert property (power_on_reset |-> ##[1:4] device_reset_req)
    else $error("power-on reset not passed on");
  ready_pulse_a: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");
endmodule : swc_sleep_wake_props
bind swc_sleep_wake swc_sleep_wake_props swc_sleep_wake_props_i (
  .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pready(pready), .sleep_instr(sleep_instr), .core_clk_en(core_clk_en),
  .prefetch_next(prefetch_next), .sleep_nop(sleep_nop), .resume(resume),
  .isr_call(isr_call), .irq_vector(irq_vector), .wdt_clear(wdt_clear),
  .lf_osc_run(lf_osc_run), .io_hold(io_hold),
  .power_on_reset(power_on_reset), .device_reset_req(device_reset_req),
  .power_state(power_state));

// ---- tb/swc_core_model.sv ----
// processor core model: issues sleep, tracks resumes and service calls
`timescale 1ns/1ps
module swc_core_model (
  input  wire logic        clk,         // system clock
  input  wire logic        reset_n,     // async reset
  input  wire logic        req,         // bench asks for a sleep
  input  wire logic        core_clk_en, // core may run
  input  wire logic        resume,      // wake finished
  input  wire logic        isr_call,    // service call
  input  wire logic [15:0] irq_vector,  // service address
  output logic             sleep_instr, // sleep instruction pulse
  output logic [7:0]       n_resume,    // resumes seen
  output logic [7:0]       n_isr,       // calls seen
  output logic [15:0]      vector_seen  // last call target
);
  // a gated core executes nothing, so sleep only leaves a clocked core
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sleep_instr <= 1'h0;
      n_resume    <= 8'h00;
      n_isr       <= 8'h00;
      vector_seen <= 16'hFFFF; // never the real vector
    end else begin
      sleep_instr <= req & core_clk_en;
      n_resume    <= n_resume + {7'h00, resume};
      n_isr       <= n_isr + {7'h00, isr_call};
      if (isr_call) vector_seen <= irq_vector; // branch target
    end
  end
endmodule : swc_core_model

// ---- tb/test_sleep_wake_control.sv ----
// self-checking bench for the sleep and wake controller
`timescale 1ns/1ps
`include "swc_cfg.svh"
module test_sleep_wake_control;
  import swc_pkg::*;
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  n_fail++; $display("wrong value %s exp %h got %h", nm, e, g); end end
  typedef struct packed {
    logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic r;
  } swc_row_type;
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  evt, rst_src; // event pulses, reset sources
  logic ext_pin, wdt_to, req, sleep_instr, core_clk_en, io_hold;
  logic wdt_sleep_run, conv_clk_run, device_reset_req, resume, isr_call;
  logic prefetch_next, sleep_nop, wdt_clear, irq_pend;
  logic [15:0] irq_vector, vector_seen;
  logic [7:0]  n_resume, n_isr;
  swc_state_type power_state;
  int n_fail, samples_checked, n_nop, n_pre, k;
  swc_row_type rows [14] = '{
    '{1'h0, 8'h00, 32'h0, 32'h0, 1'h0}, '{1'h0, 8'h04, 32'h0, 32'h0, 1'h0},
    '{1'h1, 8'h00, 32'hFFFFFFFF, 32'h0, 1'h0},
    '{1'h0, 8'h00, 32'h0, 32'h48, 1'h0},
    '{1'h1, 8'h04, 32'hFFFFFFFF, 32'h0, 1'h0},
    '{1'h0, 8'h04, 32'h0, 32'h08, 1'h0},
    '{1'h1, 8'h0C, 32'hFFFFFFFF, 32'h0, 1'h0},
    '{1'h0, 8'h0C, 32'h0, 32'h3, 1'h0}, '{1'h0, 8'h10, 32'h0, 32'h0, 1'h1},
    '{1'h1, 8'h08, 32'hFFFFFFFF, 32'h0, 1'h0},
    '{1'h0, 8'h08, 32'h0, 32'hFFF, 1'h0}, '{1'h1, 8'h08, 32'h0, 32'h0, 1'h0},
    '{1'h1, 8'h00, 32'h0, 32'h0, 1'h0}, '{1'h1, 8'h04, 32'h0, 32'h0, 1'h0}};
  swc_sleep_wake swc_sleep_wake_i (.clk(clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_instr(sleep_instr), .converter_done(evt[0]),
    .serial_port_evt(evt[1]), .bus_collision_evt(evt[2]),
    .ext_irq_pin(ext_pin), .external_reset_pin(rst_src[2]),
    .brown_out_reset(rst_src[1]), .power_on_reset(rst_src[0]),
    .wdt_timeout(wdt_to), .core_clk_en(core_clk_en),
    .prefetch_next(prefetch_next), .sleep_nop(sleep_nop), .resume(resume),
    .isr_call(isr_call), .irq_vector(irq_vector), .irq_pending(irq_pend),
    .wdt_clear(wdt_clear), .wdt_sleep_run(wdt_sleep_run), .lf_osc_run(),
    .conv_clk_run(conv_clk_run), .io_hold(io_hold),
    .device_reset_req(device_reset_req), .power_state(power_state));
  swc_core_model swc_core_model_i (.clk(clk), .reset_n(reset_n), .req(req),
    .core_clk_en(core_clk_en), .resume(resume), .isr_call(isr_call),
    .irq_vector(irq_vector), .sleep_instr(sleep_instr),
    .n_resume(n_resume), .n_isr(n_isr), .vector_seen(vector_seen));
  always #50 clk = ~clk;
  // count one-cycle pulses at the edge that ends them
  always @(posedge clk) begin
    if (sleep_nop === 1'h1) n_nop++;
    if (prefetch_next === 1'h1) n_pre++;
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    // hold the request until ready is sampled high
    do begin
      @(posedge clk);
      t++;
    end while (pready !== 1'h1 && t < 20);
    if (t >= 20) n_fail++;
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic rdck(input logic [7:0] a, input logic [31:0] e, string s);
    apb(1'h0, a, 32'h0);
    `CHK(s, e, rd)
  endtask : rdck
  task automatic pulse(input int i);
    @(posedge clk);
    evt[i] <= 1'h1;
    @(posedge clk);
    evt[i] <= 1'h0;
  endtask : pulse
  task automatic do_sleep();
    @(posedge clk);
    req <= 1'h1;
    @(posedge clk);
    req <= 1'h0;
    repeat (4) @(posedge clk);
  endtask : do_sleep
  // wait, bounded, for the core model to see one more resume
  task automatic wait_res(input logic [7:0] old);
    int t;
    t = 0;
    while (n_resume === old && t < 3000) begin
      @(posedge clk);
      t++;
    end
    if (t >= 3000) n_fail++;
    repeat (2) @(posedge clk);
  endtask : wait_res
  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  // watchdog: the whole run needs under 1500 cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    conclude();
  end
  initial begin
    {clk, reset_n, psel, penable, pwrite, req, ext_pin, wdt_to} = 8'h00;
    {paddr, pwdata, evt, rst_src} = 46'h0;
    repeat (10) @(posedge clk);
    reset_n <= 1'h1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) `CHK("read data", rows[i].e, rd)
      `CHK("slave error", rows[i].r, err)
    end
    $display("test registers done");
    pulse(0);
    pulse(2);
    rdck(8'h00, 32'h40, "flags1 set");
    rdck(8'h04, 32'h08, "flags2 set");
    apb(1'h1, 8'h08, 32'h6);
    do_sleep();
    `CHK("no-op count", 1, n_nop)
    `CHK("prefetch", 1, n_pre)
    rdck(8'h0C, 32'h3, "status no-op");
    apb(1'h1, 8'h08, 32'h4);
    do_sleep();
    `CHK("state", SWC_SLEEP, power_state)
    `CHK("conv clock", 1'h0, conv_clk_run)
    rdck(8'h0C, 32'h6, "status asleep");
    apb(1'h1, 8'h08, 32'h7);
    wait_res(8'h00);
    `CHK("calls", 8'h01, n_isr)
    `CHK("vector", 16'h0004, vector_seen)
    `CHK("irq pending", 1'h1, irq_pend)
    rdck(8'h0C, 32'h2, "status woke");
    $display("test interrupt wake done");
    apb(1'h1, 8'h00, 32'h0);
    apb(1'h1, 8'h08, 32'h6);
    do_sleep();
    pulse(0);
    wait_res(8'h01);
    `CHK("no call", 8'h01, n_isr)
    apb(1'h1, 8'h00, 32'h0);
    apb(1'h1, 8'h08, 32'h40);
    do_sleep();
    `CHK("wdt run", 1'h1, wdt_sleep_run)
    wdt_to <= 1'h1;
    repeat (4) @(posedge clk);
    wdt_to <= 1'h0;
    wait_res(8'h02);
    rdck(8'h0C, 32'h0, "status wdt");
    $display("test watchdog wake done");
    apb(1'h1, 8'h08, 32'hA20);
    do_sleep();
    `CHK("conv clock", 1'h1, conv_clk_run)
    ext_pin <= 1'h1;
    k = 0;
    while (power_state !== SWC_OST && k < 50) begin
      @(posedge clk);
      k++;
    end
    k = 0;
    while (power_state === SWC_OST && k < 3000) begin
      @(posedge clk);
      k++;
    end
    `CHK("start-up", 1024, k)
    ext_pin <= 1'h0;
    wait_res(8'h03);
    $display("test crystal wake done");
    apb(1'h1, 8'h08, 32'h180);
    for (int i = 0; i < 4; i++) begin
      if (i == 3) apb(1'h1, 8'h08, 32'h0);
      rst_src <= (i == 3) ? 3'h4 : 3'h1 << i;
      repeat (5) @(posedge clk);
      `CHK("reset req", i != 3, device_reset_req)
      rst_src <= 3'h0;
      repeat (5) @(posedge clk);
    end
    $display("test reset sources done");
    pulse(1);
    reset_n <= 1'h0;
    repeat (2) @(posedge clk);
    reset_n <= 1'h1;
    rdck(8'h00, 32'h0, "flags after reset");
    rdck(8'h0C, 32'h3, "status after reset");
    $display("test mid-run reset done");
    conclude();
  end
endmodule : test_sleep_wake_control
